// ### rtl/cansm_idle_watch.sv
// Recessive-run watcher that decides when the controller may rejoin the bus
`timescale 1ns/10ps
module cansm_idle_watch
    import cansm_pkg::*;
#(
    parameter int RUN_BITS = RECESSIVE_RUN,
    parameter int RUNS_OFF = BUS_OFF_RUNS
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic arm,
    input wire logic bus_off,
    input wire logic bit_tick,
    input wire logic rx_level,
    output logic done
);
    initial begin
        if (RUN_BITS < 2 || RUN_BITS > 255 || RUNS_OFF < 1 || RUNS_OFF > 255) begin
            $error("cansm_idle_watch: unsupported run length");
        end
    end

    localparam logic [7:0] RUN_LAST = 8'(RUN_BITS - 1);
    localparam logic [7:0] RUNS_LAST = 8'(RUNS_OFF - 1);

    logic [7:0] run_r;
    logic [7:0] runs_r;
    logic off_mode_r;
    logic run_end;

    assign run_end = bit_tick && rx_level && (run_r == RUN_LAST);

    // Bus-off state is frozen at the moment the wait starts
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            off_mode_r <= 1'b0;
        end else if (!arm) begin
            off_mode_r <= bus_off;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_r <= 8'h00;
        end else if (!arm || done) begin
            run_r <= 8'h00;
        end else if (bit_tick) begin
            run_r <= (!rx_level || run_end) ? 8'h00 : run_r + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            runs_r <= 8'h00;
        end else if (!arm || done) begin
            runs_r <= 8'h00;
        end else if (run_end) begin
            runs_r <= runs_r + 8'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            done <= 1'b0;
        end else if (!arm || done) begin
            done <= 1'b0;
        end else if (run_end) begin
            done <= !off_mode_r || (runs_r == RUNS_LAST);
        end
    end
endmodule // cansm_idle_watch

// ### rtl/cansm_mode_ctrl.sv
// CAN sleep and initialization mode controller with AHB-Lite register slave
//
// Notes on behaviour
// - Sleep entered only when no reception runs and all transmit buffers are empty.
// - Sleep acknowledge goes to 1 on entry; sleep needs request and ack both 1.
// - Setting sleep request is refused while the wake-up flag is set.
// - Sleep lasts until CPU clears request, or device clears it on bus activity.
// - CPU clear of sleep request ignored until sleep acknowledge is 1.
// - Init request enters init at once, aborting frames and dropping sync.
// - Init acknowledge goes to 1 on entry; init needs request and ack both 1.
// - Init entry resets control 0, rx/tx flags, enables, abort and buffer select.
// - Init reset of control 0 keeps wake-up enable, init and sleep requests.
// - Init reset keeps the transmitter status field of the receiver flags.
// - Init reset keeps the receiver status field of the receiver enables.
// - Control 1, timing, acceptance control, codes and masks written only in init.
// - After init exit, not bus-off, resync after 11 recessive bits.
// - After init exit in bus-off, wait for 128 runs of 11 recessive bits.
// - CPU clear of init request ignored until init acknowledge is 1.
// - Transmit pin forced recessive as soon as init is requested.
// - Transmit pin forced recessive in stop, and in wait with stop-in-wait set.
// - Transmit pin 0 means dominant, 1 means recessive.
// - CPU clearing sleep request also clears sleep acknowledge, back to run.
// - Wake-up enable lets bus traffic end sleep; otherwise traffic is ignored.
`timescale 1ns/10ps
module cansm_mode_ctrl
    import cansm_pkg::*;
#(
    parameter int BIT_CYC = BIT_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic rx_pin,
    input wire logic rx_busy,
    input wire logic tx_bit,
    input wire logic [2:0] tx_done,
    input wire logic [1:0] tx_status,
    input wire logic bus_off,
    input wire logic cpu_stop,
    input wire logic cpu_wait,
    output logic bus_tx_pin,
    output logic frame_abort,
    output logic sleep_active,
    output logic init_active
);
    initial begin
        if (BIT_CYC < 1 || BIT_CYC > 65535) begin
            $error("cansm_mode_ctrl: BIT_CYC out of range");
        end
    end

    localparam logic [15:0] BIT_LAST = 16'(BIT_CYC - 1);

    cansm_state_e state_r;
    cansm_state_e state_nxt;
    cansm_aphase_s aph_r;
    cansm_ctl0_s ctl0_r;
    logic [7:0] ctl1_r, btr0_r, btr1_r, rflg_r, rier_r, tflg_r;
    logic [7:0] tier_r, tarq_r, taak_r, tbsel_r, idac_r;
    logic [7:0] idar_r [FILT_REGS];
    logic [7:0] idmr_r [FILT_REGS];
    logic sleep_ack_r, init_ack_r;
    logic rx_s1_r, rx_s2_r, rx_s3_r, rx_lvl_r;
    logic [15:0] bit_cnt_r;
    logic bit_tick_r;
    logic resync_done;
    logic wr, in_init, out_init, wake_evt;
    logic [7:0] wd;
    logic [7:0] rd_nxt;

    // Address phase capture; writes land in the following data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aph_r <= '0;
        end else if (hready) begin
            aph_r.valid <= hsel && htrans[1] && (hsize == 3'b010);
            aph_r.write <= hwrite;
            aph_r.addr <= {haddr[7:2], 2'b00};
        end
    end

    assign wr = aph_r.valid && aph_r.write;
    assign wd = hwdata[7:0];
    assign in_init = ctl0_r.init_request && init_ack_r;
    assign out_init = !ctl0_r.init_request && !init_ack_r;
    assign wake_evt = (state_r == ST_SLEEP) && ctl0_r.wakeup_enable && !rx_lvl_r;

    // Receive pin: three stages, a change counts once stages two and three agree
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_s1_r <= 1'b1;
            rx_s2_r <= 1'b1;
            rx_s3_r <= 1'b1;
            rx_lvl_r <= 1'b1;
        end else begin
            rx_s1_r <= rx_pin;
            rx_s2_r <= rx_s1_r;
            rx_s3_r <= rx_s2_r;
            if (rx_s2_r == rx_s3_r) begin
                rx_lvl_r <= rx_s3_r;
            end
        end
    end

    // Bit clock for the recessive-run watcher; no resync to edges, so coarse only
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bit_cnt_r <= 16'h0000;
            bit_tick_r <= 1'b0;
        end else begin
            bit_tick_r <= (bit_cnt_r == BIT_LAST);
            bit_cnt_r <= (bit_cnt_r == BIT_LAST) ? 16'h0000 : bit_cnt_r + 16'h0001;
        end
    end

    cansm_idle_watch #(
        .RUN_BITS(RECESSIVE_RUN),
        .RUNS_OFF(BUS_OFF_RUNS)
    ) u_idle_watch (
        .hclk(hclk),
        .hresetn(hresetn),
        .arm(state_r == ST_RESYNC),
        .bus_off(bus_off),
        .bit_tick(bit_tick_r),
        .rx_level(rx_lvl_r),
        .done(resync_done)
    );

    // Mode sequencing
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN: begin
                if (ctl0_r.init_request) begin
                    state_nxt = ST_INIT;
                end else if (ctl0_r.sleep_request) begin
                    state_nxt = ST_SLEEP_WAIT;
                end
            end
            ST_SLEEP_WAIT: begin
                if (ctl0_r.init_request) begin
                    state_nxt = ST_INIT;
                end else if (!ctl0_r.sleep_request) begin
                    state_nxt = ST_RUN;
                end else if (!rx_busy && tflg_r[2:0] == TFLG_ALL_EMPTY) begin
                    state_nxt = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                if (ctl0_r.init_request) begin
                    state_nxt = ST_INIT;
                end else if (!ctl0_r.sleep_request || wake_evt) begin
                    state_nxt = ST_RUN;
                end
            end
            ST_INIT: begin
                if (!ctl0_r.init_request) begin
                    state_nxt = ST_RESYNC;
                end
            end
            ST_RESYNC: begin
                if (ctl0_r.init_request) begin
                    state_nxt = ST_INIT;
                end else if (resync_done) begin
                    state_nxt = ST_RUN;
                end
            end
            default: begin
                state_nxt = ST_RUN;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_r <= ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Acknowledges trail the mode by one cycle and are never written by software
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sleep_ack_r <= 1'b0;
            init_ack_r <= 1'b0;
        end else begin
            sleep_ack_r <= (state_r == ST_SLEEP) && ctl0_r.sleep_request && !wake_evt;
            init_ack_r <= (state_r == ST_INIT) && ctl0_r.init_request;
        end
    end

    // Request bits: kept through init reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl0_r.init_request <= 1'b0;
            ctl0_r.sleep_request <= 1'b0;
            ctl0_r.wakeup_enable <= 1'b0;
        end else begin
            if (wr && aph_r.addr == OFS_CTL0) begin
                if (wd[0] || init_ack_r) begin
                    ctl0_r.init_request <= wd[0];
                end
            end
            if (wake_evt) begin
                ctl0_r.sleep_request <= 1'b0;
            end else if (wr && aph_r.addr == OFS_CTL0 && !ctl0_r.init_request) begin
                if (wd[1] && !rflg_r[RFLG_WAKE_BIT]) begin
                    ctl0_r.sleep_request <= 1'b1;
                end else if (!wd[1] && sleep_ack_r) begin
                    ctl0_r.sleep_request <= 1'b0;
                end
            end
            if (wr && aph_r.addr == OFS_CTL0 && out_init) begin
                ctl0_r.wakeup_enable <= wd[2];
            end
        end
    end

    // Other control bits: held at reset value during init
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl0_r.stop_in_wait <= 1'b0;
            ctl0_r.timer_en <= 1'b0;
            ctl0_r.synced <= 1'b0;
            ctl0_r.frame_rx <= 1'b0;
            ctl0_r.rx_active <= 1'b0;
        end else begin
            ctl0_r.frame_rx <= 1'b0;
            ctl0_r.rx_active <= rx_busy && !ctl0_r.init_request;
            if (state_r == ST_INIT || state_r == ST_RESYNC) begin
                ctl0_r.synced <= 1'b0;
            end else if (state_r == ST_RUN) begin
                ctl0_r.synced <= 1'b1;
            end
            if (in_init) begin
                ctl0_r.stop_in_wait <= 1'b0;
                ctl0_r.timer_en <= 1'b0;
            end else if (wr && aph_r.addr == OFS_CTL0 && out_init) begin
                ctl0_r.stop_in_wait <= wd[5];
                ctl0_r.timer_en <= wd[3];
            end
        end
    end

    // Receiver flags: wake-up flag set wins over write-one-to-clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rflg_r <= RST_REG;
        end else begin
            rflg_r[3:2] <= tx_status;
            if (wake_evt) begin
                rflg_r[RFLG_WAKE_BIT] <= 1'b1;
            end else if (in_init) begin
                rflg_r[RFLG_WAKE_BIT] <= 1'b0;
            end else if (wr && aph_r.addr == OFS_RFLG && out_init && wd[RFLG_WAKE_BIT]) begin
                rflg_r[RFLG_WAKE_BIT] <= 1'b0;
            end
            if (in_init) begin
                rflg_r[3:2] <= rflg_r[3:2];
            end
        end
    end

    // Transmit flags: buffer-empty flags cleared by writing one, set by completion
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tflg_r <= RST_TFLG;
        end else if (in_init) begin
            tflg_r <= RST_TFLG;
        end else begin
            for (int i = 0; i < 3; i++) begin
                if (tx_done[i]) begin
                    tflg_r[i] <= 1'b1;
                end else if (wr && aph_r.addr == OFS_TFLG && out_init && wd[i]) begin
                    tflg_r[i] <= 1'b0;
                end
            end
        end
    end

    // Enables, abort and select registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rier_r <= RST_REG;
            tier_r <= RST_REG;
            tarq_r <= RST_REG;
            taak_r <= RST_REG;
            tbsel_r <= RST_REG;
        end else if (in_init) begin
            rier_r <= rier_r & RIER_RX_STATUS_MASK;
            tier_r <= RST_REG;
            tarq_r <= RST_REG;
            taak_r <= RST_REG;
            tbsel_r <= RST_REG;
        end else if (wr) begin
            case (aph_r.addr)
                OFS_RIER: rier_r <= wd;
                OFS_TIER: tier_r <= out_init ? wd : tier_r;
                OFS_TARQ: tarq_r <= wd;
                OFS_TAAK: taak_r <= wd;
                OFS_TBSEL: tbsel_r <= wd;
                default: tarq_r <= tarq_r;
            endcase
        end
    end

    // Configuration registers locked outside init
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctl1_r <= RST_REG;
            btr0_r <= RST_REG;
            btr1_r <= RST_REG;
            idac_r <= RST_REG;
        end else if (wr && in_init) begin
            case (aph_r.addr)
                OFS_CTL1: ctl1_r <= wd & CTL1_RW_MASK;
                OFS_BTR0: btr0_r <= wd;
                OFS_BTR1: btr1_r <= wd;
                OFS_IDAC: idac_r <= wd;
                default: idac_r <= idac_r;
            endcase
        end
    end

    for (genvar g = 0; g < FILT_REGS; g++) begin : g_filt
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                idar_r[g] <= RST_REG;
                idmr_r[g] <= RST_REG;
            end else if (wr && in_init) begin
                if (aph_r.addr == OFS_IDAR + 8'(4 * g)) begin
                    idar_r[g] <= wd;
                end
                if (aph_r.addr == OFS_IDMR + 8'(4 * g)) begin
                    idmr_r[g] <= wd;
                end
            end
        end
    end

    // Read mux, registered at the address phase so data stand for the data phase
    always_comb begin
        rd_nxt = 8'h00;
        case ({haddr[7:2], 2'b00})
            OFS_CTL0: rd_nxt = ctl0_r;
            OFS_CTL1: rd_nxt = {ctl1_r[7:2], sleep_ack_r, init_ack_r};
            OFS_BTR0: rd_nxt = btr0_r;
            OFS_BTR1: rd_nxt = btr1_r;
            OFS_RFLG: rd_nxt = rflg_r;
            OFS_RIER: rd_nxt = rier_r;
            OFS_TFLG: rd_nxt = tflg_r;
            OFS_TIER: rd_nxt = tier_r;
            OFS_TARQ: rd_nxt = tarq_r;
            OFS_TAAK: rd_nxt = taak_r;
            OFS_TBSEL: rd_nxt = tbsel_r;
            OFS_IDAC: rd_nxt = idac_r;
            default: rd_nxt = 8'h00;
        endcase
        for (int i = 0; i < FILT_REGS; i++) begin
            if ({haddr[7:2], 2'b00} == OFS_IDAR + 8'(4 * i)) begin
                rd_nxt = idar_r[i];
            end
            if ({haddr[7:2], 2'b00} == OFS_IDMR + 8'(4 * i)) begin
                rd_nxt = idmr_r[i];
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (hready && hsel && htrans[1] && !hwrite) begin
                hrdata <= {24'h00_0000, rd_nxt};
            end
        end
    end

    // Transmit pin and mode outputs; recessive is 1 and wins over the transmitter
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_tx_pin <= 1'b1;
            frame_abort <= 1'b0;
            sleep_active <= 1'b0;
            init_active <= 1'b0;
        end else begin
            if (ctl0_r.init_request || (wr && aph_r.addr == OFS_CTL0 && wd[0])) begin
                bus_tx_pin <= 1'b1;
            end else if (cpu_stop || (cpu_wait && ctl0_r.stop_in_wait)) begin
                bus_tx_pin <= 1'b1;
            end else if (state_r != ST_RUN || !ctl0_r.synced) begin
                bus_tx_pin <= 1'b1;
            end else begin
                bus_tx_pin <= tx_bit;
            end
            frame_abort <= (state_r != ST_INIT) && (state_nxt == ST_INIT);
            sleep_active <= ctl0_r.sleep_request && sleep_ack_r;
            init_active <= in_init;
        end
    end
endmodule // cansm_mode_ctrl

// ### rtl/cansm_pkg.sv
// Package: register map, field layouts and timing constants of the CAN mode controller
package cansm_pkg;
    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] OFS_CTL0 = 8'h00;
    localparam logic [7:0] OFS_CTL1 = 8'h04;
    localparam logic [7:0] OFS_BTR0 = 8'h08;
    localparam logic [7:0] OFS_BTR1 = 8'h0c;
    localparam logic [7:0] OFS_RFLG = 8'h10;
    localparam logic [7:0] OFS_RIER = 8'h14;
    localparam logic [7:0] OFS_TFLG = 8'h18;
    localparam logic [7:0] OFS_TIER = 8'h1c;
    localparam logic [7:0] OFS_TARQ = 8'h20;
    localparam logic [7:0] OFS_TAAK = 8'h24;
    localparam logic [7:0] OFS_TBSEL = 8'h28;
    localparam logic [7:0] OFS_IDAC = 8'h2c;
    localparam logic [7:0] OFS_IDAR = 8'h40;
    localparam logic [7:0] OFS_IDMR = 8'h60;
    localparam int FILT_REGS = 8;

    // Reset values
    localparam logic [7:0] RST_REG = 8'h00;
    localparam logic [7:0] RST_TFLG = 8'h07;

    // Field positions and preserved-field masks
    localparam int RFLG_WAKE_BIT = 7;
    localparam int RIER_WAKE_BIT = 7;
    localparam int CTL1_SLEEP_ACK_BIT = 1;
    localparam int CTL1_INIT_ACK_BIT = 0;
    localparam logic [7:0] RFLG_TX_STATUS_MASK = 8'h0c;
    localparam logic [7:0] RIER_RX_STATUS_MASK = 8'h0c;
    localparam logic [7:0] CTL1_RW_MASK = 8'hfc;
    localparam logic [2:0] TFLG_ALL_EMPTY = 3'h7;

    // Bus timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int BIT_TIME_NS = 1000;
    localparam int BIT_CYCLES = BIT_TIME_NS / CLK_PERIOD_NS;
    localparam int RECESSIVE_RUN = 11;
    localparam int BUS_OFF_RUNS = 128;

    typedef struct packed {
        logic frame_rx;
        logic rx_active;
        logic stop_in_wait;
        logic synced;
        logic timer_en;
        logic wakeup_enable;
        logic sleep_request;
        logic init_request;
    } cansm_ctl0_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } cansm_aphase_s;

    typedef enum logic [2:0] {
        ST_RUN = 3'b000,
        ST_SLEEP_WAIT = 3'b001,
        ST_SLEEP = 3'b011,
        ST_INIT = 3'b010,
        ST_RESYNC = 3'b110
    } cansm_state_e;
endpackage

// ### tb/cansm_bus_model.sv
// Bus model: wired-AND of the controller pin with dominant bits of other nodes
`timescale 1ns/10ps
module cansm_bus_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic tx,
    input wire logic dom,
    output logic rx_pin = 1'b1
);
    // Registered so the loop back into the controller has no zero-delay path
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_pin <= 1'b1;
        end else begin
            rx_pin <= tx & ~dom;
        end
    end
endmodule // cansm_bus_model

// ### tb/cansm_mode_ctrl_monitor.sv
// Checker on the mode and pin ports of the mode controller
`timescale 1ns/10ps
module cansm_mode_ctrl_monitor (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cpu_stop,
    input wire logic bus_tx_pin,
    input wire logic frame_abort,
    input wire logic sleep_active,
    input wire logic init_active
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    property p_init_rec;
        init_active |-> bus_tx_pin;
    endproperty
    a_init_rec: assert property (p_init_rec) else $error("pin dominant in init");
    property p_abort_on_entry;
        $rose(init_active) |-> $past(frame_abort, 2);
    endproperty
    a_abort_on_entry: assert property (p_abort_on_entry) else $error("no abort");
    property p_abort_in_init;
        frame_abort |-> ##2 init_active;
    endproperty
    a_abort_in_init: assert property (p_abort_in_init) else $error("stray abort");
    property p_abort_pulse;
        frame_abort |=> !frame_abort;
    endproperty
    a_abort_pulse: assert property (p_abort_pulse) else $error("long abort");
    property p_stop_rec;
        cpu_stop |=> bus_tx_pin;
    endproperty
    a_stop_rec: assert property (p_stop_rec) else $error("pin dominant in stop");
    // Resync needs 11 bit times, so the pin cannot leave recessive early
    property p_resync_rec;
        $fell(init_active) |-> bus_tx_pin [*8];
    endproperty
    a_resync_rec: assert property (p_resync_rec) else $error("early rejoin");
    property p_sleep_rec;
        sleep_active |-> bus_tx_pin;
    endproperty
    a_sleep_rec: assert property (p_sleep_rec) else $error("pin dominant asleep");
    property p_rec_before_ack;
        $rose(init_active) |-> $past(bus_tx_pin);
    endproperty
    a_rec_before_ack: assert property (p_rec_before_ack) else $error("late recessive");
endmodule // cansm_mode_ctrl_monitor

bind cansm_mode_ctrl cansm_mode_ctrl_monitor i_cansm_mode_ctrl_monitor (
    .hclk(hclk), .hresetn(hresetn), .cpu_stop(cpu_stop), .bus_tx_pin(bus_tx_pin),
    .frame_abort(frame_abort), .sleep_active(sleep_active), .init_active(init_active));

// ### tb/cansm_mode_ctrl_tb.sv
// Self-checking bench of the CAN mode controller
`timescale 1ns/10ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module cansm_mode_ctrl_tb
    import cansm_pkg::*;
;
    logic hclk, hreadyout, hresp, rx_pin, bus_tx_pin, frame_abort, sleep_active, init_active;
    logic hresetn = 0, hwrite = 0, rx_busy = 0, tx_bit = 1, bus_off = 0, dom = 0, rv = 0;
    logic cpu_stop = 0, cpu_wait = 0, pv = 0;
    logic [1:0] htrans = 0, tx_status = 2'b10;
    logic [2:0] tx_done = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata;
    logic [15:0] exp_q[$];
    logic [15:0] nt;
    int n_errors = 0, num_checks = 0, cyc = 0, seed = 78446, i;
    // Short bit time keeps the bus-off wait of 128 runs inside the run budget
    cansm_mode_ctrl #(.BIT_CYC(2)) i_cansm_mode_ctrl (.hclk(hclk), .hresetn(hresetn),
        .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
        .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .rx_pin(rx_pin), .rx_busy(rx_busy), .tx_bit(tx_bit), .tx_done(tx_done),
        .tx_status(tx_status), .bus_off(bus_off), .cpu_stop(cpu_stop), .cpu_wait(cpu_wait),
        .bus_tx_pin(bus_tx_pin), .frame_abort(frame_abort), .sleep_active(sleep_active),
        .init_active(init_active));
    cansm_bus_model i_cansm_bus_model (.hclk(hclk), .hresetn(hresetn), .tx(bus_tx_pin),
        .dom(dom), .rx_pin(rx_pin));
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic bus(input logic w, input logic [7:0] a, d);
        haddr <= {24'h0, a};
        hwrite <= w;
        htrans <= 2'b10;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        htrans <= 2'b00;
        hwdata <= {24'h0, d};
        rv <= !w;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rv <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, e, m);
        exp_q.push_back({m, e});
        bus(1'b0, a, 8'h00);
    endtask
    task automatic pins(input logic [2:0] e);
        exp_q.push_back({8'h07, 5'h0, e});
        pv <= 1'b1;
        @(posedge hclk);
        pv <= 1'b0;
    endtask
    task automatic pulse(input int n);
        dom <= 1'b1;
        repeat (n) @(posedge hclk);
        dom <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask
    always @(posedge hclk) begin
        if (rv) `CHK(hresp, 1'b0)
        if ((rv && hreadyout) || pv) begin
            nt = exp_q.pop_front();
            `CHK((rv ? hrdata[7:0] : {5'h0, bus_tx_pin, sleep_active, init_active}) & nt[15:8], nt[7:0])
        end
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            summarize();
        end
    end
    initial begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        repeat (2) @(posedge hclk);
        rd(OFS_CTL0, 8'h10, 8'hff);
        rd(OFS_CTL1, 8'h00, 8'hff);
        rd(8'h30, 8'h00, 8'hff);
        wr(OFS_CTL1, 8'hfc);
        wr(OFS_IDMR, 8'h5a);
        rd(OFS_CTL1, 8'h00, 8'hff);
        rd(OFS_IDMR, 8'h00, 8'hff);
        $display("test lock done");
        rx_busy <= 1'b1;
        wr(OFS_CTL0, 8'h06);
        repeat (8) @(posedge hclk);
        pins(3'b100);
        wr(OFS_CTL0, 8'h04);
        rd(OFS_CTL0, 8'h02, 8'h02);
        rx_busy <= 1'b0;
        repeat (8) @(posedge hclk);
        pins(3'b110);
        rd(OFS_CTL1, 8'h02, 8'h03);
        pulse(6);
        pins(3'b100);
        rd(OFS_CTL0, 8'h00, 8'h02);
        rd(OFS_RFLG, 8'h80, 8'h80);
        wr(OFS_CTL0, 8'h06);
        rd(OFS_CTL0, 8'h00, 8'h02);
        wr(OFS_RFLG, 8'h80);
        wr(OFS_CTL0, 8'h02);
        repeat (8) @(posedge hclk);
        pulse(6);
        pins(3'b110);
        wr(OFS_CTL0, 8'h00);
        repeat (3) @(posedge hclk);
        pins(3'b100);
        rd(OFS_CTL1, 8'h00, 8'h03);
        $display("test sleep done");
        wr(OFS_RIER, 8'h8c);
        wr(OFS_TIER, 8'h07);
        wr(OFS_CTL0, 8'h2c);
        wr(OFS_TFLG, 8'h01);
        rd(OFS_TFLG, 8'h06, 8'hff);
        wr(OFS_CTL0, 8'h2d);
        repeat (3) @(posedge hclk);
        pins(3'b101);
        rd(OFS_CTL0, 8'h05, 8'hff);
        rd(OFS_RFLG, 8'h08, 8'hff);
        rd(OFS_RIER, 8'h0c, 8'hff);
        rd(OFS_TIER, 8'h00, 8'hff);
        rd(OFS_TFLG, 8'h07, 8'hff);
        wr(OFS_CTL1, 8'hfc);
        rd(OFS_CTL1, 8'hfd, 8'hff);
        for (i = 0; i < 2 * FILT_REGS; i++) begin
            wr(OFS_IDAR + 8'(4 * i), 8'(i + 3));
            rd(OFS_IDAR + 8'(4 * i), 8'(i + 3), 8'hff);
        end
        wr(OFS_IDAC, 8'h5a);
        rd(OFS_IDAC, 8'h5a, 8'hff);
        wr(OFS_CTL0, 8'h04);
        rd(OFS_CTL0, 8'h00, 8'h11);
        repeat (40) @(posedge hclk);
        rd(OFS_CTL0, 8'h10, 8'h11);
        $display("test init done");
        wr(OFS_CTL0, 8'h24);
        tx_bit <= 1'b0;
        repeat (3) @(posedge hclk);
        pins(3'b000);
        cpu_wait <= 1'b1;
        repeat (3) @(posedge hclk);
        pins(3'b100);
        wr(OFS_CTL0, 8'h04);
        repeat (3) @(posedge hclk);
        pins(3'b000);
        cpu_wait <= 1'b0;
        cpu_stop <= 1'b1;
        repeat (3) @(posedge hclk);
        pins(3'b100);
        cpu_stop <= 1'b0;
        repeat (6) begin
            tx_bit <= 1'($random(seed));
            repeat (3) @(posedge hclk);
            pins({tx_bit, 2'b00});
        end
        $display("test pin done");
        tx_bit <= 1'b1;
        bus_off <= 1'b1;
        repeat (6) @(posedge hclk);
        wr(OFS_CTL0, 8'h06);
        repeat (8) @(posedge hclk);
        pins(3'b110);
        wr(OFS_CTL0, 8'h07);
        repeat (4) @(posedge hclk);
        wr(OFS_CTL0, 8'h04);
        repeat (200) @(posedge hclk);
        rd(OFS_CTL0, 8'h00, 8'h10);
        repeat (3000) @(posedge hclk);
        rd(OFS_CTL0, 8'h10, 8'h10);
        $display("test bus-off done");
        summarize();
    end
endmodule // cansm_mode_ctrl_tb
